// *** src/tcm_timer.sv ***
// 16-bit timer/counter with two compare channels, reached over APB.
// Assumes an APB master on CLK and ack pulses from an interrupt unit.
`timescale 1ns/1ns
`include "tcm_defines.svh"

module tcm_timer
   import tcm_pkg::*;
(
   input  wire logic                   CLK,        // System clock, 125 MHz
   input  wire logic                   NRST,       // Sync reset, active low
   input  wire logic                   PSEL,       // APB select
   input  wire logic                   PENABLE,    // APB access phase
   input  wire logic                   PWRITE,     // APB direction
   input  wire logic [`TCM_ADDR_W-1:0] PADDR,      // APB byte address
   input  wire logic [31:0]            PWDATA,     // APB write data
   output logic      [31:0]            PRDATA,     // APB read data
   output logic                        PREADY,     // APB ready
   output logic                        PSLVERR,    // APB error
   input  wire logic                   OVF_ACK,    // Overflow serviced
   input  wire logic [1:0]             MATCH_ACK,  // Match serviced
   output logic                        OVF_FLAG,   // Overflow flag
   output logic      [1:0]             MATCH_FLAG, // Compare match flags
   output logic      [1:0]             OC_STATE,   // Compare output states
   output logic      [1:0]             OC_PIN_EN   // Port override enables
);

   // ***************************************************************
   // APB decode
   // ***************************************************************
   logic        setup;
   logic        wr;
   logic        mapped;
   logic        wr_ctrl;
   logic        wr_count;
   logic        wr_cmpa;
   logic        wr_cmpb;
   logic        wr_status;
   logic        wr_force;

   // Setup samples read data so the access phase answers at once
   assign setup     = PSEL && !PENABLE;
   assign wr        = PSEL && PENABLE && PWRITE;
   assign mapped    = (PADDR == `TCM_OFS_CTRL)   || (PADDR == `TCM_OFS_COUNT)
                   || (PADDR == `TCM_OFS_CMPA)   || (PADDR == `TCM_OFS_CMPB)
                   || (PADDR == `TCM_OFS_STATUS) || (PADDR == `TCM_OFS_FORCE);
   assign wr_ctrl   = wr && (PADDR == `TCM_OFS_CTRL);
   assign wr_count  = wr && (PADDR == `TCM_OFS_COUNT);
   assign wr_cmpa   = wr && (PADDR == `TCM_OFS_CMPA);
   assign wr_cmpb   = wr && (PADDR == `TCM_OFS_CMPB);
   assign wr_status = wr && (PADDR == `TCM_OFS_STATUS);
   assign wr_force  = wr && (PADDR == `TCM_OFS_FORCE);
   assign PREADY    = 1'b1;
   assign PSLVERR   = PSEL && PENABLE && !mapped;

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   logic [10:0]            ctrl;
   logic [10:0]            next_ctrl;
   tcm_cmp_cfg_type [1:0]  cfg;
   tcm_cmp_cfg_type [1:0]  next_cfg;
   logic [3:0]             wgm;
   logic                   pwm;

   // Compare values load directly; no double buffer in any mode
   always_comb begin
      next_ctrl = ctrl;
      next_cfg  = cfg;
      if (wr_ctrl) begin
         next_ctrl = PWDATA[10:0];
      end
      if (wr_cmpa) begin
         next_cfg[0].ocr = PWDATA[`TCM_CNT_W-1:0];
      end
      if (wr_cmpb) begin
         next_cfg[1].ocr = PWDATA[`TCM_CNT_W-1:0];
      end
      next_cfg[0].com = next_ctrl[`TCM_CTRL_COMA];
      next_cfg[1].com = next_ctrl[`TCM_CTRL_COMB];
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         ctrl <= `TCM_CTRL_RST;
         cfg  <= '0;
      end else begin
         ctrl <= next_ctrl;
         cfg  <= next_cfg;
      end
   end

   assign wgm = ctrl[`TCM_CTRL_WGM];
   assign pwm = (wgm == `TCM_WGM_FPWM8);

   // ***************************************************************
   // Prescaler
   // ***************************************************************
   logic [`TCM_DIV_W-1:0] div;
   logic [`TCM_DIV_W-1:0] next_div;
   logic [`TCM_DIV_W-1:0] last;
   logic                  tick;

   // Terminal count per clock select; stop yields no tick at all
   always_comb begin
      case (ctrl[`TCM_CTRL_CS])
         `TCM_CS_DIV8:    last = `TCM_LAST8;
         `TCM_CS_DIV64:   last = `TCM_LAST64;
         `TCM_CS_DIV256:  last = `TCM_LAST256;
         `TCM_CS_DIV1024: last = `TCM_LAST1024;
         default:         last = '0;
      endcase
      tick     = 1'b0;
      next_div = '0;
      if (ctrl[`TCM_CTRL_CS] == `TCM_CS_DIV1) begin
         tick = 1'b1;
      end else if (ctrl[`TCM_CTRL_CS] != `TCM_CS_STOP && last != '0) begin
         tick     = (div >= last);
         next_div = tick ? '0 : div + 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         div <= '0;
      end else begin
         div <= next_div;
      end
   end

   // ***************************************************************
   // Counter and write blocking
   // ***************************************************************
   logic [`TCM_CNT_W-1:0] cnt;
   logic [`TCM_CNT_W-1:0] next_cnt;
   logic [`TCM_CNT_W-1:0] top;
   logic                  at_top;
   logic                  blk_pend;
   logic                  next_blk_pend;

   // Top comes from the waveform mode alone, never the output field
   assign top    = pwm ? `TCM_TOP8 : `TCM_MAX;
   assign at_top = (cnt >= top);

   // A write wins over a tick; blocking lasts until the next tick
   always_comb begin
      next_cnt      = cnt;
      next_blk_pend = blk_pend;
      if (wr_count) begin
         next_cnt      = PWDATA[`TCM_CNT_W-1:0];
         next_blk_pend = 1'b1;
      end else if (tick) begin
         next_cnt      = at_top ? `TCM_FLOOR : cnt + 1'b1;
         next_blk_pend = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         cnt      <= `TCM_FLOOR;
         blk_pend <= 1'b0;
      end else begin
         cnt      <= next_cnt;
         blk_pend <= next_blk_pend;
      end
   end

   // ***************************************************************
   // Compare channels
   // ***************************************************************
   tcm_evt_type evt;
   logic [1:0]  hit;
   logic [1:0]  force_stb;

   assign evt = '{tick:   tick,
                  block:  blk_pend || wr_count,
                  pwm:    pwm,
                  at_top: at_top};
   // Strobes are ignored in PWM modes and never touch counter or flags
   assign force_stb  = wr_force && !pwm ?
                       {PWDATA[`TCM_FRC_B], PWDATA[`TCM_FRC_A]} : 2'b00;

   for (genvar i = 0; i < 2; i++) begin : g_cmp
      tcm_cmp_unit #(
         .WIDTH     (`TCM_CNT_W)
      ) u_cmp (
         .clk       (CLK),
         .nrst      (NRST),
         .evt       (evt),
         .cfg       (cfg[i]),
         .cnt       (cnt),
         .force_stb (force_stb[i]),
         .hit       (hit[i]),
         .state     (OC_STATE[i]),
         .pin_en    (OC_PIN_EN[i])
      );
   end

   // ***************************************************************
   // Flags
   // ***************************************************************
   logic       ovf_set;
   logic       next_ovf;
   logic [1:0] next_mflag;
   logic [1:0] sw_mclr;

   assign ovf_set = tick && !wr_count && at_top;
   assign sw_mclr = wr_status ? {PWDATA[`TCM_ST_MB], PWDATA[`TCM_ST_MA]} : 2'b00;

   // Sticky flags: a set in the same cycle as a clear wins
   always_comb begin
      next_ovf   = OVF_FLAG;
      next_mflag = MATCH_FLAG;
      if (OVF_ACK || (wr_status && PWDATA[`TCM_ST_OVF])) begin
         next_ovf = 1'b0;
      end
      if (ovf_set) begin
         next_ovf = 1'b1;
      end
      next_mflag = (MATCH_FLAG & ~(MATCH_ACK | sw_mclr)) | hit;
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         OVF_FLAG   <= 1'b0;
         MATCH_FLAG <= 2'b00;
      end else begin
         OVF_FLAG   <= next_ovf;
         MATCH_FLAG <= next_mflag;
      end
   end

   // ***************************************************************
   // Read data
   // ***************************************************************
   logic [31:0] next_prdata;

   // Force reads as zero: strobes hold no state
   always_comb begin
      next_prdata = '0;
      if (setup && !PWRITE) begin
         case (PADDR)
            `TCM_OFS_CTRL:   next_prdata[10:0] = ctrl;
            `TCM_OFS_COUNT:  next_prdata[`TCM_CNT_W-1:0] = cnt;
            `TCM_OFS_CMPA:   next_prdata[`TCM_CNT_W-1:0] = cfg[0].ocr;
            `TCM_OFS_CMPB:   next_prdata[`TCM_CNT_W-1:0] = cfg[1].ocr;
            `TCM_OFS_STATUS: next_prdata[2:0] = {MATCH_FLAG, OVF_FLAG};
            default:         next_prdata = '0;
         endcase
      end else if (PSEL && PENABLE) begin
         next_prdata = PRDATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         PRDATA <= '0;
      end else begin
         PRDATA <= next_prdata;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   a_wrap_floor: assert property (@(posedge CLK) disable iff (!NRST)
      (tick && !wr_count && !pwm && cnt == `TCM_MAX) |=> cnt == `TCM_FLOOR)
      else $error("counter did not wrap to zero");
   a_ovf_same: assert property (@(posedge CLK) disable iff (!NRST)
      (tick && !wr_count && at_top) |=> (OVF_FLAG && cnt == `TCM_FLOOR))
      else $error("overflow flag not set with zero");
   a_ovf_sticky: assert property (@(posedge CLK) disable iff (!NRST)
      (OVF_FLAG && !OVF_ACK && !wr_status) |=> OVF_FLAG)
      else $error("overflow flag cleared by counting");
   a_cnt_load: assert property (@(posedge CLK) disable iff (!NRST)
      wr_count |=> cnt == $past(PWDATA[`TCM_CNT_W-1:0]))
      else $error("counter write not taken");
   a_cnt_step: assert property (@(posedge CLK) disable iff (!NRST)
      (tick && !wr_count && !at_top) |=> cnt == $past(cnt) + 16'h0001)
      else $error("counter did not advance");
   a_cnt_hold: assert property (@(posedge CLK) disable iff (!NRST)
      (!tick && !wr_count) |=> $stable(cnt))
      else $error("counter moved without tick");
   a_flag_next: assert property (@(posedge CLK) disable iff (!NRST)
      hit[0] |=> MATCH_FLAG[0])
      else $error("match flag not set after match");
   a_force_quiet: assert property (@(posedge CLK) disable iff (!NRST)
      (force_stb[0] && !hit[0] && !MATCH_FLAG[0]) |=> !MATCH_FLAG[0])
      else $error("forced compare set match flag");
   a_mode_count: assert property (@(posedge CLK) disable iff (!NRST)
      (tick && !wr_count && !pwm && cnt == `TCM_TOP8) |=> cnt != `TCM_FLOOR)
      else $error("normal mode wrapped early");

endmodule : tcm_timer

// *** pkg/tcm_defines.svh ***
// Offsets, fields, reset values and counts of the timer/compare block.
// Included by the package and by every design file that needs a figure.
`ifndef TCM_DEFINES_SVH
`define TCM_DEFINES_SVH

// Widths
`define TCM_CNT_W      16
`define TCM_ADDR_W     8
`define TCM_DIV_W      10

// Register byte offsets
`define TCM_OFS_CTRL   8'h00
`define TCM_OFS_COUNT  8'h04
`define TCM_OFS_CMPA   8'h08
`define TCM_OFS_CMPB   8'h0C
`define TCM_OFS_STATUS 8'h10
`define TCM_OFS_FORCE  8'h14

// Control fields
`define TCM_CTRL_WGM   3:0
`define TCM_CTRL_COMA  5:4
`define TCM_CTRL_COMB  7:6
`define TCM_CTRL_CS    10:8
`define TCM_CTRL_RST   11'h000

// Status and force bits
`define TCM_ST_OVF     0
`define TCM_ST_MA      1
`define TCM_ST_MB      2
`define TCM_FRC_A      0
`define TCM_FRC_B      1

// Waveform generation modes served
`define TCM_WGM_NORMAL 4'h0
`define TCM_WGM_FPWM8  4'h5

// Counter landmarks
`define TCM_MAX        16'hFFFF
`define TCM_TOP8       16'h00FF
`define TCM_FLOOR      16'h0000

// Compare output mode encodings
`define TCM_COM_OFF    2'h0
`define TCM_COM_TOGGLE 2'h1
`define TCM_COM_CLEAR  2'h2
`define TCM_COM_SET    2'h3

// Clock select and divider terminal counts
`define TCM_CS_STOP    3'h0
`define TCM_CS_DIV1    3'h1
`define TCM_CS_DIV8    3'h2
`define TCM_CS_DIV64   3'h3
`define TCM_CS_DIV256  3'h4
`define TCM_CS_DIV1024 3'h5
`define TCM_LAST8      10'h007
`define TCM_LAST64     10'h03F
`define TCM_LAST256    10'h0FF
`define TCM_LAST1024   10'h3FF

`endif

// *** pkg/tcm_pkg.sv ***
// Types shared by the timer top and its compare units.
// Assumes tcm_defines.svh is on the include path.
`include "tcm_defines.svh"

package tcm_pkg;

   // One compare channel's setting, travels as a unit
   typedef struct packed {
      logic [1:0]              com;
      logic [`TCM_CNT_W-1:0]   ocr;
   } tcm_cmp_cfg_type;

   // Timer events seen by each compare unit
   typedef struct packed {
      logic tick;
      logic block;
      logic pwm;
      logic at_top;
   } tcm_evt_type;

endpackage : tcm_pkg

// *** src/tcm_cmp_unit.sv ***
// One output compare channel: match detect and compare output state.
// Assumes tick and block come from the timer top on the same clock.
`timescale 1ns/1ns
`include "tcm_defines.svh"

module tcm_cmp_unit
   import tcm_pkg::*;
#(
   parameter int WIDTH = `TCM_CNT_W
) (
   input  wire logic             clk,       // System clock
   input  wire logic             nrst,      // Sync reset, active low
   input  wire tcm_evt_type      evt,       // Tick, block, mode, top
   input  wire tcm_cmp_cfg_type  cfg,       // Mode field and compare value
   input  wire logic [WIDTH-1:0] cnt,       // Current counter value
   input  wire logic             force_stb, // Force strobe, one cycle
   output logic                  hit,       // Qualified match this tick
   output logic                  state,     // Compare output state
   output logic                  pin_en     // Port override request
);

   // ***************************************************************
   // Elaboration check
   // ***************************************************************
   if (WIDTH < 2 || WIDTH > `TCM_CNT_W) begin : g_chk
      $error("tcm_cmp_unit: WIDTH out of range");
   end

   logic next_state;

   // Match only on a tick, never in the cycle after a counter write
   assign hit    = evt.tick && !evt.block && (cnt == cfg.ocr[WIDTH-1:0]);
   // Override follows the field at once; only the state waits for a match
   assign pin_en = (cfg.com != `TCM_COM_OFF);

   // ***************************************************************
   // Output state
   // ***************************************************************
   // Field is sampled only at a match, a force strobe or, in PWM, the top, so a new value waits for one
   always_comb begin
      next_state = state;
      if (!evt.pwm) begin
         if (hit || force_stb) begin
            case (cfg.com)
               `TCM_COM_TOGGLE: next_state = !state;
               `TCM_COM_CLEAR:  next_state = 1'b0;
               `TCM_COM_SET:    next_state = 1'b1;
               default:         next_state = state;
            endcase
         end
      end else begin
         // Polarity chosen by the field; toggle code is no action here
         if (hit && cfg.com[1]) begin
            next_state = (cfg.com == `TCM_COM_CLEAR);
         end
         if (evt.tick && evt.at_top && cfg.com[1]) begin
            next_state = (cfg.com == `TCM_COM_SET);
         end
      end
   end

   // State survives mode changes; a mode write never clears it, reset does
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   a_zero_keep: assert property (@(posedge clk) disable iff (!nrst)
      (hit && !force_stb && cfg.com == `TCM_COM_OFF) |=> $stable(state))
      else $error("state moved with mode field zero");
   a_force_apply: assert property (@(posedge clk) disable iff (!nrst)
      (!evt.pwm && force_stb && cfg.com == `TCM_COM_TOGGLE) |=> state != $past(state))
      else $error("force strobe did not toggle state");
   a_pwm_polar: assert property (@(posedge clk) disable iff (!nrst)
      (evt.pwm && hit && !evt.at_top && cfg.com == `TCM_COM_SET) |=> !state)
      else $error("inverted pwm match did not clear state");
   a_block_match: assert property (@(posedge clk) disable iff (!nrst)
      (evt.block && !force_stb && !evt.pwm) |=> $stable(state))
      else $error("state moved while blocked");
   a_reset_state: assert property (@(posedge clk) disable iff (!nrst)
      $rose(nrst) |-> !state)
      else $error("state not zero after reset");

endmodule : tcm_cmp_unit

// *** verif/tb_tcm_timer.sv ***
// Self-checking bench for the timer/compare block, driven over APB.
// Assumes tcm_pkg and the design files are compiled first, and that
// tcm_defines.svh is on the include path.
`timescale 1ns/1ns
`include "tcm_defines.svh"

module tb_tcm_timer
   import tcm_pkg::*;
();

   // ***************************************************************
   // Signals
   // ***************************************************************
   logic        CLK;        // System clock
   logic        NRST;       // Sync reset, active low
   logic        PSEL;       // APB select
   logic        PENABLE;    // APB access phase
   logic        PWRITE;     // APB direction
   logic [7:0]  PADDR;      // APB byte address
   logic [31:0] PWDATA;     // APB write data
   logic [31:0] PRDATA;     // APB read data
   logic        PREADY;     // APB ready
   logic        PSLVERR;    // APB error
   logic        OVF_ACK;    // Overflow serviced
   logic [1:0]  MATCH_ACK;  // Match serviced
   logic        OVF_FLAG;   // Overflow flag
   logic [1:0]  MATCH_FLAG; // Match flags
   logic [1:0]  OC_STATE;   // Output states
   logic [1:0]  OC_PIN_EN;  // Override enables
   int          n_errors;   // Mismatches seen
   int          compares;   // Comparisons made
   logic [31:0] rd;         // Last read data
   logic        err;        // Last error response
   int          n;          // Cycle count of a measurement
   // Force table: mode field applied and resulting state
   logic [1:0]  coms [6] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
   logic        oexp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

   tcm_timer tcm_timer_i (
      .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .OVF_ACK(OVF_ACK), .MATCH_ACK(MATCH_ACK),
      .OVF_FLAG(OVF_FLAG), .MATCH_FLAG(MATCH_FLAG), .OC_STATE(OC_STATE),
      .OC_PIN_EN(OC_PIN_EN)
   );

   // Clock, 8 ns period
   always #4 CLK = ~CLK;

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // One APB transfer; read data and error taken at the ready edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= wr;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      // No wait limit here: only the watchdog may end a stalled transfer
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      rd      = PRDATA;
      err     = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask : rdc

   // Lets registered outputs land before they are looked at
   task automatic settle;
      repeat (2) @(posedge CLK);
      #1;
   endtask : settle

   function automatic logic [31:0] ctl(input logic [2:0] cs, input logic [1:0] com,
                                       input logic [3:0] wgm);
      return {21'h0, cs, com, com, wgm};
   endfunction : ctl

   // Runs from 0x0008 up to the compare value 0x0010, then stops and clears both match flags
   task automatic run_match(input logic [1:0] com);
      int k;
      wr(`TCM_OFS_COUNT, 32'h0000_0008);
      wr(`TCM_OFS_CTRL, ctl(`TCM_CS_DIV1, com, `TCM_WGM_NORMAL));
      k = 0;
      while (MATCH_FLAG !== 2'b11 && k < 40) begin
         @(posedge CLK);
         k++;
      end
      // Eight ticks to reach the compare value, one to set the flag, one to see it
      check(32'(k), 32'h0000_000A);
      wr(`TCM_OFS_CTRL, ctl(`TCM_CS_STOP, com, `TCM_WGM_NORMAL));
      wr(`TCM_OFS_STATUS, 32'h0000_0006);
   endtask : run_match

   // Length of the active level of a fast PWM pulse, top 0x00FF
   task automatic pwm_len(input logic [1:0] com, input logic lvl);
      wr(`TCM_OFS_COUNT, 32'h0000_0000);
      wr(`TCM_OFS_CTRL, ctl(`TCM_CS_DIV1, com, `TCM_WGM_FPWM8));
      n = 0;
      while (OC_STATE[0] === lvl && n < 600) begin @(posedge CLK); n++; end
      while (OC_STATE[0] !== lvl && n < 600) begin @(posedge CLK); n++; end
      n = 0;
      while (OC_STATE[0] === lvl && n < 600) begin @(posedge CLK); n++; end
      check(32'(n), 32'(`TCM_TOP8 - 16'h0080));
   endtask : pwm_len

   task automatic print_verdict;
      if (n_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   // ***************************************************************
   // Tests
   // ***************************************************************
   // Main sequence; timer kept stopped wherever exact values are read
   initial begin
      CLK = 1'b0; NRST = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0;
      PADDR = 8'h00; PWDATA = 32'h0; OVF_ACK = 1'b0; MATCH_ACK = 2'b00;
      n_errors = 0;
      compares = 0;
      repeat (5) @(posedge CLK);
      NRST <= 1'b1;
      #1;
      check(32'(OC_STATE), 32'h0);
      check(32'({OVF_FLAG, MATCH_FLAG, OC_PIN_EN}), 32'h0);
      rdc(`TCM_OFS_CTRL, 32'h0);
      rdc(8'h18, 32'h0);
      check(32'(err), 32'h1);
      rdc(`TCM_OFS_FORCE, 32'h0);
      // Stopped counter takes a write and holds it
      wr(`TCM_OFS_COUNT, 32'h0000_1234);
      repeat (10) @(posedge CLK);
      rdc(`TCM_OFS_COUNT, 32'h0000_1234);
      // Wrap from the top, overflow, match without clearing the count
      wr(`TCM_OFS_CMPA, 32'h0000_0003);
      wr(`TCM_OFS_CMPB, 32'h0000_0003);
      wr(`TCM_OFS_COUNT, 32'h0000_FFFD);
      wr(`TCM_OFS_CTRL, ctl(`TCM_CS_DIV1, 2'h0, `TCM_WGM_NORMAL));
      @(posedge CLK);
      #1;
      check(32'(OVF_FLAG), 32'h0);
      n = 0;
      while (OVF_FLAG !== 1'b1 && n < 10) begin @(posedge CLK); n++; end
      check(32'(OVF_FLAG), 32'h1);
      n = 0;
      while (MATCH_FLAG !== 2'b11 && n < 12) begin @(posedge CLK); n++; end
      check(32'(MATCH_FLAG), 32'h3);
      wr(`TCM_OFS_CTRL, ctl(`TCM_CS_STOP, 2'h0, `TCM_WGM_NORMAL));
      apb(1'b0, `TCM_OFS_COUNT, 32'h0);
      check(32'(rd > 32'h3 && rd < 32'h40), 32'h1);
      check(32'(OVF_FLAG), 32'h1);
      OVF_ACK   <= 1'b1;
      MATCH_ACK <= 2'b01;
      @(posedge CLK);
      OVF_ACK   <= 1'b0;
      MATCH_ACK <= 2'b00;
      settle;
      check(32'({OVF_FLAG, MATCH_FLAG}), 32'h2);
      wr(`TCM_OFS_STATUS, 32'h0000_0004);
      settle;
      check(32'(MATCH_FLAG), 32'h0);
      // Forced compares in normal mode, every mode field value
      wr(`TCM_OFS_COUNT, 32'h0000_0055);
      for (int i = 0; i < 6; i++) begin
         wr(`TCM_OFS_CTRL, ctl(`TCM_CS_STOP, coms[i], `TCM_WGM_NORMAL));
         wr(`TCM_OFS_FORCE, 32'h0000_0003);
         settle;
         check(32'(OC_STATE), 32'({2{oexp[i]}}));
         check(32'(OC_PIN_EN), 32'({2{coms[i] != 2'h0}}));
      end
      check(32'(MATCH_FLAG), 32'h0);
      rdc(`TCM_OFS_COUNT, 32'h0000_0055);
      // Real matches: field zero keeps state, a new field waits for a match
      wr(`TCM_OFS_CMPA, 32'h0000_0010);
      wr(`TCM_OFS_CMPB, 32'h0000_0010);
      run_match(2'h0);
      settle;
      check(32'(OC_STATE), 32'h3);
      wr(`TCM_OFS_CTRL, ctl(`TCM_CS_STOP, 2'h2, `TCM_WGM_NORMAL));
      settle;
      check(32'(OC_STATE), 32'h3);
      run_match(2'h2);
      settle;
      check(32'(OC_STATE), 32'h0);
      // Counter loaded with the compare value: first match is blocked
      wr(`TCM_OFS_COUNT, 32'h0000_0010);
      wr(`TCM_OFS_CTRL, ctl(`TCM_CS_DIV1, 2'h1, `TCM_WGM_NORMAL));
      repeat (6) @(posedge CLK);
      wr(`TCM_OFS_CTRL, ctl(`TCM_CS_STOP, 2'h1, `TCM_WGM_NORMAL));
      settle;
      check(32'({MATCH_FLAG, OC_STATE}), 32'h0);
      // Divide by eight: ten ticks land before the stop write takes hold
      wr(`TCM_OFS_COUNT, 32'h0000_0000);
      wr(`TCM_OFS_CTRL, ctl(`TCM_CS_DIV8, 2'h0, `TCM_WGM_NORMAL));
      repeat (79) @(posedge CLK);
      wr(`TCM_OFS_CTRL, ctl(`TCM_CS_STOP, 2'h0, `TCM_WGM_NORMAL));
      rdc(`TCM_OFS_COUNT, 32'h0000_000A);
      // Fast PWM both polarities, same active pulse length for the clear and set fields
      wr(`TCM_OFS_CMPA, 32'h0000_0080);
      wr(`TCM_OFS_CMPB, 32'h0000_0080);
      pwm_len(2'h2, 1'b1);
      pwm_len(2'h3, 1'b0);
      // Force is refused in PWM mode; state was just set at top
      wr(`TCM_OFS_CTRL, ctl(`TCM_CS_STOP, 2'h2, `TCM_WGM_FPWM8));
      wr(`TCM_OFS_FORCE, 32'h0000_0003);
      settle;
      check(32'(OC_STATE), 32'h3);
      print_verdict;
   end

   // Watchdog; the tests take about a thousand cycles
   initial begin
      repeat (20000) @(posedge CLK);
      n_errors++;
      print_verdict;
   end

endmodule : tb_tcm_timer
